// *** uef_enhanced_flow.sv ***
// Enhanced feature, divisor, flow threshold and trigger level registers of one channel
// Function
// RULE1: With clear-to-send flow enabled, transmitter halts while clear-to-send input is high.
// RULE2: Auto request-to-send goes high at halt level, low at resume level.
// RULE3: Special detect compares each character with second stop character; stored, flag set.
// RULE4: Enhanced bit clear blocks writes to upper interrupt, fifo and modem bits.
// RULE5: Low nibble of enhanced register selects software flow control combination.
// RULE6: Baud divisor is sixteen bits, high latch is the upper byte.
// RULE7: Divisor latch writes are ignored once sleep enable is set.
// RULE8: Threshold register holds resume high nibble, halt low nibble, steps of four.
// RULE9: Threshold register writable only with enhanced bit and modem bit six set.
// RULE10: Software keeps halt above resume; hardware does not check.
// RULE11: Software loads thresholds before enabling automatic flow control.
// RULE12: Trigger register holds receive high nibble, transmit low nibble, times four.
// RULE13: Trigger register writable only with enhanced bit and modem bit six set.
// RULE14: Zero trigger nibble falls back to fifo-control level, per direction.
// RULE15: Software leaves fifo-control receive trigger bits at zero when trigger register used.
// RULE16: Ready register: bit5 rx B, bit4 rx A, bit1 tx B, bit0 tx A.
// RULE17: Ready register read-only at address seven, modem bit two set, no loopback.
// RULE18: Special character sets identification bit four at priority level five.
// RULE19: Enhanced register reached at address two with line control set to key.
// RULE20: Threshold and trigger reached at six and seven with modem bit six.
// RULE21: Divisor latches reached at zero and one with line control bit seven.
// RULE22: Ready bits mirror each channel's trigger-derived receive and transmit readiness.
// RULE23: Enhanced, threshold and trigger registers clear to zero on reset.
`timescale 1ns/1ps
module uef_enhanced_flow (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire uef_pkg::uef_bus_t bus,
  input  wire logic              channel_a_select_n,
  input  wire logic              channel_b_select_n,
  input  wire logic              clear_to_send_in_n,
  input  wire logic [6:0]        rx_fill,
  input  wire logic [6:0]        tx_fill,
  input  wire logic [7:0]        rx_char,
  input  wire logic              rx_char_valid,
  input  wire logic              rx_ready_b,
  input  wire logic              tx_ready_b,
  output logic [7:0]             read_data,
  output logic [15:0]            baud_divisor,
  output logic                   tx_halt,
  output logic                   request_to_send_out_n,
  output logic                   rx_store,
  output logic                   special_char_flag,
  output logic [3:0]             sw_flow_mode,
  output logic [6:0]             rx_trigger,
  output logic [6:0]             tx_trigger,
  output logic                   rx_ready_a,
  output logic                   tx_ready_a
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] scale4(input logic [3:0] nib);
    return {1'b0, nib, 2'b00};
  endfunction

  // Protected bits keep their old value unless enhanced writes are on
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask, input logic enh);
    return enh ? new_v : ((old_v & mask) | (new_v & ~mask));
  endfunction

  function automatic logic [6:0] fcr_rx_level(input logic [1:0] sel);
    return (sel == 2'h0) ? uef_pkg::FCR_RX_LVL0 : (sel == 2'h1) ? uef_pkg::FCR_RX_LVL1 :
           (sel == 2'h2) ? uef_pkg::FCR_RX_LVL2 : uef_pkg::FCR_RX_LVL3;
  endfunction

  function automatic logic [6:0] fcr_tx_level(input logic [1:0] sel);
    return (sel == 2'h0) ? uef_pkg::FCR_TX_LVL0 : (sel == 2'h1) ? uef_pkg::FCR_TX_LVL1 :
           (sel == 2'h2) ? uef_pkg::FCR_TX_LVL2 : uef_pkg::FCR_TX_LVL3;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] enhanced_feature_control, dll, divisor_high_byte, flow_threshold_control, fifo_trigger_levels, interrupt_enable_reg, fifo_control_reg, line_control_reg, modem_control_reg, second_stop_char;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  wire sel_a    = !channel_a_select_n;
  wire sel_any  = sel_a || !channel_b_select_n;
  wire wr       = bus.wr && sel_a;
  wire efr_mode = (line_control_reg == uef_pkg::LCR_EFR_KEY);
  wire dl_mode  = line_control_reg[uef_pkg::LCR_DL_BIT];
  wire norm     = !dl_mode;
  wire enh      = enhanced_feature_control[uef_pkg::EFR_ENH_BIT];
  wire ext      = enh && modem_control_reg[uef_pkg::MCR_EXT_BIT];
  wire frdy_en  = modem_control_reg[uef_pkg::MCR_FRDY_BIT] && !modem_control_reg[uef_pkg::MCR_LOOP_BIT];
  wire sleep    = interrupt_enable_reg[uef_pkg::IER_SLEEP_BIT];

  wire wr_efr   = wr && efr_mode && (bus.addr == uef_pkg::ADDR_EFR);       // RULE19
  wire wr_second_stop_char = wr && efr_mode && (bus.addr == uef_pkg::ADDR_SECOND_STOP_CHAR);
  wire dl_try   = wr && dl_mode && !efr_mode;                              // RULE21
  wire wr_dll   = dl_try && !sleep && (bus.addr == uef_pkg::ADDR_DLL);     // RULE7
  wire wr_dlm   = dl_try && !sleep && (bus.addr == uef_pkg::ADDR_DLM);     // RULE7
  wire wr_ier   = wr && norm && (bus.addr == uef_pkg::ADDR_IER);
  wire wr_fcr   = wr && norm && (bus.addr == uef_pkg::ADDR_FCR);
  wire wr_lcr   = wr && (bus.addr == uef_pkg::ADDR_LCR);
  wire wr_mcr   = wr && norm && (bus.addr == uef_pkg::ADDR_MCR);
  wire tcr_try  = wr && norm && (bus.addr == uef_pkg::ADDR_TCR);
  wire tlr_try  = wr && norm && (bus.addr == uef_pkg::ADDR_TLR) && !frdy_en;
  wire wr_tcr   = tcr_try && ext;                                          // RULE9 RULE20
  wire wr_tlr   = tlr_try && ext;                                          // RULE13 RULE20
  wire rd_frdy  = bus.rd && sel_any && norm && frdy_en
                  && (bus.addr == uef_pkg::ADDR_FRDY);                     // RULE17
  wire rd_iir   = bus.rd && sel_a && norm && (bus.addr == uef_pkg::ADDR_IIR);

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  wire [7:0] next_ier = merge(interrupt_enable_reg, bus.data, uef_pkg::IER_PROT_MASK, enh);   // RULE4
  wire [7:0] next_fcr = merge(fifo_control_reg, bus.data, uef_pkg::FCR_PROT_MASK, enh);   // RULE4
  wire [7:0] next_mcr = merge(modem_control_reg, bus.data, uef_pkg::MCR_PROT_MASK, enh);   // RULE4

  wire       spec_hit = enhanced_feature_control[uef_pkg::EFR_SPEC_BIT] && rx_char_valid
                        && (rx_char == second_stop_char);                              // RULE3
  // A hit in the clearing read cycle keeps the flag set
  wire       next_spec = spec_hit || (special_char_flag && !rd_iir);       // RULE18

  wire [6:0] next_rx_trig = (fifo_trigger_levels[7:4] != uef_pkg::NIB_ZERO) ? scale4(fifo_trigger_levels[7:4])
                            : fcr_rx_level(fifo_control_reg[7:6]);                       // RULE12 RULE14
  wire [6:0] next_tx_trig = (fifo_trigger_levels[3:0] != uef_pkg::NIB_ZERO) ? scale4(fifo_trigger_levels[3:0])
                            : fcr_tx_level(fifo_control_reg[5:4]);                       // RULE12 RULE14
  wire [6:0] tx_space     = uef_pkg::FIFO_DEPTH - tx_fill;

  wire [7:0] iir_val  = {{2{fifo_control_reg[uef_pkg::FCR_EN_BIT]}}, 1'b0, special_char_flag,
                         3'h0, !special_char_flag};                         // RULE18
  wire [7:0] frdy_val = {2'h0, rx_ready_b, rx_ready_a, 2'h0, tx_ready_b, tx_ready_a}; // RULE16

  logic [7:0] next_read;
  always_comb begin
    if (rd_frdy) next_read = frdy_val;
    else if (!(bus.rd && sel_a)) next_read = read_data;
    else if (bus.addr == uef_pkg::ADDR_LCR) next_read = line_control_reg;
    else if (efr_mode && bus.addr == uef_pkg::ADDR_EFR) next_read = enhanced_feature_control;
    else if (efr_mode && bus.addr == uef_pkg::ADDR_SECOND_STOP_CHAR) next_read = second_stop_char;
    else if (dl_mode && bus.addr == uef_pkg::ADDR_DLL) next_read = dll;
    else if (dl_mode && bus.addr == uef_pkg::ADDR_DLM) next_read = divisor_high_byte;
    else if (dl_mode) next_read = uef_pkg::REG_RESET;
    else if (bus.addr == uef_pkg::ADDR_IER) next_read = interrupt_enable_reg;
    else if (bus.addr == uef_pkg::ADDR_IIR) next_read = iir_val;
    else if (bus.addr == uef_pkg::ADDR_MCR) next_read = modem_control_reg;
    else if (ext && bus.addr == uef_pkg::ADDR_TCR) next_read = flow_threshold_control;
    else if (ext && bus.addr == uef_pkg::ADDR_TLR) next_read = fifo_trigger_levels;
    else next_read = uef_pkg::REG_RESET;
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      enhanced_feature_control   <= uef_pkg::REG_RESET;                                          // RULE23
      flow_threshold_control   <= uef_pkg::REG_RESET;                                          // RULE23
      fifo_trigger_levels   <= uef_pkg::REG_RESET;                                          // RULE23
      dll   <= uef_pkg::REG_RESET;
      divisor_high_byte   <= uef_pkg::REG_RESET;
      interrupt_enable_reg   <= uef_pkg::REG_RESET;
      fifo_control_reg   <= uef_pkg::REG_RESET;
      line_control_reg   <= uef_pkg::REG_RESET;
      modem_control_reg   <= uef_pkg::REG_RESET;
      second_stop_char <= uef_pkg::REG_RESET;
    end else begin
      if (wr_efr)   enhanced_feature_control   <= bus.data;
      if (wr_second_stop_char) second_stop_char <= bus.data;
      if (wr_dll)   dll   <= bus.data;
      if (wr_dlm)   divisor_high_byte   <= bus.data;
      if (wr_ier)   interrupt_enable_reg   <= next_ier;
      if (wr_fcr)   fifo_control_reg   <= next_fcr;
      if (wr_lcr)   line_control_reg   <= bus.data;
      if (wr_mcr)   modem_control_reg   <= next_mcr;
      if (wr_tcr)   flow_threshold_control   <= bus.data;                                      // RULE8
      if (wr_tlr)   fifo_trigger_levels   <= bus.data;
    end
  end

  // ----------------------------------------------------------------
  // Status and flow outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      read_data         <= uef_pkg::REG_RESET;
      tx_halt           <= 1'b0;
      rx_store          <= 1'b0;
      special_char_flag <= 1'b0;
      rx_trigger        <= uef_pkg::FCR_RX_LVL0;
      tx_trigger        <= uef_pkg::FCR_TX_LVL0;
      rx_ready_a        <= 1'b0;
      tx_ready_a        <= 1'b0;
    end else begin
      read_data         <= next_read;
      tx_halt           <= enhanced_feature_control[uef_pkg::EFR_CTS_BIT] && clear_to_send_in_n;   // RULE1
      rx_store          <= rx_char_valid;                                     // RULE3
      special_char_flag <= next_spec;                                         // RULE3
      rx_trigger        <= next_rx_trig;
      tx_trigger        <= next_tx_trig;
      rx_ready_a        <= rx_fill >= rx_trigger;                             // RULE22
      tx_ready_a        <= tx_space >= tx_trigger;                            // RULE22
    end
  end

  assign baud_divisor = {divisor_high_byte, dll};                                           // RULE6
  assign sw_flow_mode = enhanced_feature_control[3:0];                                             // RULE5

  // Thresholds taken as programmed; ordering is software's duty
  uef_rts_hyst u_rts (
    .clock        (clock),
    .srst         (srst),
    .enable       (enhanced_feature_control[uef_pkg::EFR_RTS_BIT]),
    .manual_rts   (modem_control_reg[uef_pkg::MCR_RTS_BIT]),
    .fill         (rx_fill),
    .halt_level   (scale4(flow_threshold_control[3:0])),                                         // RULE8
    .resume_level (scale4(flow_threshold_control[7:4])),                                         // RULE8 RULE10
    .rts_n        (request_to_send_out_n)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_spec_hit;
    enhanced_feature_control[uef_pkg::EFR_SPEC_BIT] && rx_char_valid && (rx_char == second_stop_char);
  endsequence
  sequence s_spec_seen;
    special_char_flag && rx_store && !read_data[0] [*1];
  endsequence

  cts_halt_a: assert property (enhanced_feature_control[7] && clear_to_send_in_n |=> tx_halt) // RULE1
    else $error("transmit not halted by clear-to-send");
  rts_halt_a: assert property (enhanced_feature_control[6] && rx_fill >= scale4(flow_threshold_control[3:0])
                               |=> request_to_send_out_n) // RULE2
    else $error("request-to-send not raised at halt level");
  spec_flag_a: assert property (s_spec_hit |=> special_char_flag && rx_store) // RULE3
    else $error("special character not flagged");
  ier_guard_a: assert property (wr_ier && !enh |=> interrupt_enable_reg[7:4] == $past(interrupt_enable_reg[7:4])) // RULE4
    else $error("protected interrupt bits changed");
  div_sleep_a: assert property (dl_try && sleep |=> $stable(baud_divisor)) // RULE7
    else $error("divisor written in sleep");
  tcr_lock_a: assert property (tcr_try && !ext |=> $stable(flow_threshold_control)) // RULE9
    else $error("threshold register written while locked");
  tlr_lock_a: assert property (tlr_try && !ext |=> $stable(fifo_trigger_levels)) // RULE13
    else $error("trigger register written while locked");
  trig_sel_a: assert property (fifo_trigger_levels[7:4] == uef_pkg::NIB_ZERO
                               |=> rx_trigger == fcr_rx_level($past(fifo_control_reg[7:6]))) // RULE14
    else $error("receive trigger ignores fifo-control level");
  frdy_zero_a: assert property (rd_frdy |=> read_data[7:6] == 2'h0 && read_data[3:2] == 2'h0) // RULE16
    else $error("ready register unused bits set");
  spec_read_a: assert property (rd_iir && !spec_hit |=> !special_char_flag) // RULE18
    else $error("special flag not cleared by read");
  rst_clear_a: assert property (disable iff (1'b0) srst |=> enhanced_feature_control == 8'h00 && flow_threshold_control == 8'h00
                                && fifo_trigger_levels == 8'h00) // RULE23
    else $error("enhanced registers not cleared by reset");

endmodule // uef_enhanced_flow

// *** uef_pkg.sv ***
// Shared constants and types for the enhanced feature and flow configuration block
package uef_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DLL   = 3'h0;
  localparam logic [2:0] ADDR_DLM   = 3'h1;
  localparam logic [2:0] ADDR_IER   = 3'h1;
  localparam logic [2:0] ADDR_EFR   = 3'h2;
  localparam logic [2:0] ADDR_FCR   = 3'h2;
  localparam logic [2:0] ADDR_IIR   = 3'h2;
  localparam logic [2:0] ADDR_LCR   = 3'h3;
  localparam logic [2:0] ADDR_MCR   = 3'h4;
  localparam logic [2:0] ADDR_TCR   = 3'h6;
  localparam logic [2:0] ADDR_TLR   = 3'h7;
  localparam logic [2:0] ADDR_SECOND_STOP_CHAR = 3'h7;
  localparam logic [2:0] ADDR_FRDY  = 3'h7;

  // ----------------------------------------------------------------
  // Field positions, keys, masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LCR_EFR_KEY = 8'hBF;
  localparam int LCR_DL_BIT   = 7;
  localparam int EFR_CTS_BIT  = 7;
  localparam int EFR_RTS_BIT  = 6;
  localparam int EFR_SPEC_BIT = 5;
  localparam int EFR_ENH_BIT  = 4;
  localparam int IER_SLEEP_BIT = 4;
  localparam int MCR_EXT_BIT  = 6;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MCR_FRDY_BIT = 2;
  localparam int MCR_RTS_BIT  = 1;
  localparam int FCR_EN_BIT   = 0;
  localparam logic [7:0] IER_PROT_MASK = 8'hF0;
  localparam logic [7:0] FCR_PROT_MASK = 8'h30;
  localparam logic [7:0] MCR_PROT_MASK = 8'hE0;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [3:0] NIB_ZERO      = 4'h0;

  // ----------------------------------------------------------------
  // FIFO levels
  // ----------------------------------------------------------------
  localparam logic [6:0] FIFO_DEPTH  = 7'h40;
  localparam logic [6:0] FCR_RX_LVL0 = 7'h08;
  localparam logic [6:0] FCR_RX_LVL1 = 7'h10;
  localparam logic [6:0] FCR_RX_LVL2 = 7'h38;
  localparam logic [6:0] FCR_RX_LVL3 = 7'h3C;
  localparam logic [6:0] FCR_TX_LVL0 = 7'h08;
  localparam logic [6:0] FCR_TX_LVL1 = 7'h10;
  localparam logic [6:0] FCR_TX_LVL2 = 7'h20;
  localparam logic [6:0] FCR_TX_LVL3 = 7'h38;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] data;
  } uef_bus_t;

  typedef struct packed {
    logic rx_b;
    logic rx_a;
    logic tx_b;
    logic tx_a;
  } uef_ready_t;

endpackage

// *** uef_rts_hyst.sv ***
// Request-to-send hysteresis between halt and resume levels
`timescale 1ns/1ps
module uef_rts_hyst (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       enable,
  input  wire logic       manual_rts,
  input  wire logic [6:0] fill,
  input  wire logic [6:0] halt_level,
  input  wire logic [6:0] resume_level,
  output logic            rts_n
);
  logic next_rts_n;

  // Between the two levels the line holds, giving hysteresis
  assign next_rts_n = !enable                ? !manual_rts :
                      (fill >= halt_level)   ? 1'b1 :       // RULE2
                      (fill <= resume_level) ? 1'b0 :       // RULE2
                      rts_n;

  always_ff @(posedge clock) begin
    if (srst) rts_n <= 1'b1;
    else      rts_n <= next_rts_n;
  end
endmodule // uef_rts_hyst

// *** uef_peer_model.sv ***
// Remote serial peer model: flow-control lines and received character stream
`timescale 1ns/1ps
module uef_peer_model (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       busy,
  input  wire logic       send_req,
  input  wire logic [7:0] send_char,
  input  wire logic       request_to_send_out_n,
  output logic            clear_to_send_in_n,
  output logic [7:0]      rx_char,
  output logic            rx_char_valid
);
  // Busy peer shows clear-to-send high, meaning stop
  assign clear_to_send_in_n = busy;
  // Idle line churns so stale data never looks valid
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_char       <= 8'hA5;
      rx_char_valid <= 1'b0;
    end else if (send_req && !request_to_send_out_n) begin
      rx_char       <= send_char;
      rx_char_valid <= 1'b1;
    end else begin
      rx_char       <= ~rx_char;
      rx_char_valid <= 1'b0;
    end
  end
endmodule // uef_peer_model

// *** uart_enhanced_flow_config_bench.sv ***
// Self-checking bench for the enhanced feature and flow configuration block
`timescale 1ns/1ps
module uart_enhanced_flow_config_bench;
  localparam int LIMIT = 3000;
  logic              clock;
  logic              srst;
  uef_pkg::uef_bus_t bus;
  logic              channel_a_select_n;
  logic              channel_b_select_n;
  logic              clear_to_send_in_n;
  logic [6:0]        rx_fill;
  logic [6:0]        tx_fill;
  logic [7:0]        rx_char;
  logic              rx_char_valid;
  logic              rx_ready_b;
  logic              tx_ready_b;
  logic [7:0]        read_data;
  logic [15:0]       baud_divisor;
  logic              tx_halt;
  logic              request_to_send_out_n;
  logic              rx_store;
  logic              special_char_flag;
  logic [3:0]        sw_flow_mode;
  logic [6:0]        rx_trigger;
  logic [6:0]        tx_trigger;
  logic              rx_ready_a;
  logic              tx_ready_a;
  logic              busy;
  logic              send_req;
  logic [7:0]        send_char;
  logic [7:0]        rd_val;
  int                err_count = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                stores = 0;
  logic [6:0]        fill_seq [6] = '{7'h10, 7'h09, 7'h08, 7'h0C, 7'h10, 7'h08};
  logic              rts_seq [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  uef_enhanced_flow DUT (.clock(clock), .srst(srst), .bus(bus),
    .channel_a_select_n(channel_a_select_n), .channel_b_select_n(channel_b_select_n),
    .clear_to_send_in_n(clear_to_send_in_n), .rx_fill(rx_fill), .tx_fill(tx_fill),
    .rx_char(rx_char), .rx_char_valid(rx_char_valid), .rx_ready_b(rx_ready_b),
    .tx_ready_b(tx_ready_b), .read_data(read_data), .baud_divisor(baud_divisor),
    .tx_halt(tx_halt), .request_to_send_out_n(request_to_send_out_n), .rx_store(rx_store),
    .special_char_flag(special_char_flag), .sw_flow_mode(sw_flow_mode),
    .rx_trigger(rx_trigger), .tx_trigger(tx_trigger), .rx_ready_a(rx_ready_a),
    .tx_ready_a(tx_ready_a));
  uef_peer_model PEER (.clock(clock), .srst(srst), .busy(busy), .send_req(send_req),
    .send_char(send_char), .request_to_send_out_n(request_to_send_out_n),
    .clear_to_send_in_n(clear_to_send_in_n), .rx_char(rx_char),
    .rx_char_valid(rx_char_valid));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Strobe is one cycle, so every access leaves an idle edge behind it
  task automatic bus_op(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{wr: w, rd: !w, addr: a, data: d};
    @(posedge clock);
    bus <= '0;
    #1 rd_val = read_data;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus_op(1'b1, a, d);
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    bus_op(1'b0, a, 8'h00);
    chk_out({8'h00, rd_val}, {8'h00, exp}, what);
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic send(input logic [7:0] c);
    @(posedge clock);
    send_req  <= 1'b1;
    send_char <= c;
    @(posedge clock);
    send_req <= 1'b0;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (rx_store === 1'b1)
      stores <= stores + 1;
    if (cycles == LIMIT) begin
      err_count++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    bus = '0;
    channel_a_select_n = 1'b0;
    channel_b_select_n = 1'b1;
    rx_fill = 7'h00;
    tx_fill = 7'h00;
    rx_ready_b = 1'b0;
    tx_ready_b = 1'b0;
    busy = 1'b0;
    send_req = 1'b0;
    send_char = 8'h00;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    #1;
    chk_out(16'(request_to_send_out_n), 16'h0001, "rts reset");
    chk_out(baud_divisor, 16'h0000, "divisor reset");
    chk_out(16'(sw_flow_mode), 16'h0000, "sw flow reset");
    chk_out(16'(rx_trigger), 16'(uef_pkg::FCR_RX_LVL0), "rx trig reset");
    @(posedge clock);
    busy <= 1'b1;
    settle();
    chk_out(16'(tx_halt), 16'h0000, "cts flow off");
    $display("test reset done");
    wr(3'h1, 8'hF3);
    chk_rd(3'h1, 8'h03, "ier locked");
    wr(3'h4, 8'hE2);
    chk_rd(3'h4, 8'h02, "mcr locked");
    wr(3'h7, 8'h33);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    settle();
    chk_out(16'(tx_trigger), 16'(uef_pkg::FCR_TX_LVL0), "tlr locked");
    chk_out(baud_divisor, 16'h1234, "divisor");
    $display("test protection done");
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'h1A);
    chk_rd(3'h2, 8'h1A, "efr readback");
    chk_out(16'(sw_flow_mode), 16'h000A, "sw flow mode");
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h10);
    chk_rd(3'h1, 8'h10, "ier unlocked");
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h55);
    settle();
    chk_out(baud_divisor, 16'h1234, "divisor in sleep");
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h40);
    wr(3'h7, 8'h35);
    settle();
    chk_out(16'(rx_trigger), 16'h000C, "rx trigger");
    chk_out(16'(tx_trigger), 16'h0014, "tx trigger");
    wr(3'h2, 8'h21);
    wr(3'h7, 8'h30);
    settle();
    chk_out(16'(tx_trigger), 16'(uef_pkg::FCR_TX_LVL2), "fcr fallback");
    chk_out(16'(rx_trigger), 16'h000C, "rx keeps tlr");
    wr(3'h4, 8'h00);
    wr(3'h7, 8'h00);
    settle();
    chk_out(16'(rx_trigger), 16'h000C, "tlr needs mcr6");
    $display("test triggers done");
    wr(3'h4, 8'h40);
    wr(3'h6, 8'h24);
    wr(3'h4, 8'h00);
    wr(3'h6, 8'h01);
    wr(3'h4, 8'h40);
    chk_rd(3'h6, 8'h24, "tcr gated");
    wr(3'h3, 8'hBF);
    wr(3'h7, 8'h13);
    wr(3'h2, 8'hFA);
    wr(3'h3, 8'h00);
    foreach (fill_seq[i]) begin
      @(posedge clock);
      rx_fill <= fill_seq[i];
      settle();
      chk_out(16'(request_to_send_out_n), 16'(rts_seq[i]), "auto rts");
    end
    chk_out(16'(tx_halt), 16'h0001, "cts stop");
    @(posedge clock);
    busy <= 1'b0;
    settle();
    chk_out(16'(tx_halt), 16'h0000, "cts go");
    $display("test flow done");
    send(8'h41);
    settle();
    chk_out(16'(special_char_flag), 16'h0000, "no match");
    send(8'h13);
    settle();
    chk_out(16'(stores), 16'h0002, "chars stored");
    chk_out(16'(special_char_flag), 16'h0001, "special flag");
    chk_rd(3'h2, 8'hD0, "iir special");
    chk_rd(3'h2, 8'hC1, "iir cleared");
    $display("test special done");
    @(posedge clock);
    rx_fill <= 7'h0C;
    tx_fill <= 7'h3C;
    tx_ready_b <= 1'b1;
    wr(3'h4, 8'h44);
    settle();
    chk_out({14'h0000, rx_ready_a, tx_ready_a}, 16'h0002, "ready a");
    chk_rd(3'h7, 8'h12, "ready reg");
    @(posedge clock);
    tx_fill <= 7'h00;
    rx_ready_b <= 1'b1;
    channel_a_select_n <= 1'b1;
    channel_b_select_n <= 1'b0;
    settle();
    chk_rd(3'h7, 8'h33, "ready via b");
    @(posedge clock);
    channel_a_select_n <= 1'b0;
    channel_b_select_n <= 1'b1;
    wr(3'h7, 8'hFF);
    settle();
    chk_out(16'(rx_trigger), 16'h000C, "ready read only");
    wr(3'h4, 8'h54);
    chk_rd(3'h7, 8'h30, "loopback hides ready");
    $display("test ready done");
    final_report();
  end
endmodule // uart_enhanced_flow_config_bench
